/* File: src/wdrc_top.sv */
// Chosen here: the register offsets and the APB register port.
`include "wdrc_consts.svh"
`default_nettype none
module wdrc_top #(
    parameter int POR_DELAY_CYC = `WDRC_POR_DELAY_CYC,
    parameter int FAULT_DELAY_CYC = `WDRC_FAULT_DELAY_CYC,
    parameter int BOR_FILTER_CYC = `WDRC_BOR_FILTER_CYC,
    parameter int SLOW_DIV = `WDRC_SLOW_DIV
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // processor core
    input wire logic clear_watchdog_instruction_i,
    input wire logic halt_i,
    input wire logic low_power_mode_i,
    input wire logic power_down_i,
    input wire logic slow_source_crystal_i,
    // pins
    input wire logic crystal_slow_oscillator_i,
    input wire logic low_supply_i,
    // reset control
    output logic device_reset_o,
    output logic cpu_run_o,
    output logic port_preset_o,
    output logic pc_sp_clear_o,
    output logic [1:0] brownout_threshold_o,
    output logic idle_clock_keep_o
);
    if (POR_DELAY_CYC < 1 || FAULT_DELAY_CYC < 4 || BOR_FILTER_CYC < 2 ||
        SLOW_DIV < 1 || SLOW_DIV > 65536)
    begin : g_bad_param
        $error("wdrc_top: unsupported parameter value");
    end

    wdrc_cnt_if cnt_if ();

    wdrc_counter u_counter (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .bus(cnt_if.cnt)
    );

    logic [7:0] watchdog_control;
    logic [7:0] brownout_level_select;
    logic idle_clock_keep;
    logic watchdog_key_fault_flag;
    logic level_select_fault_flag;
    logic brownout_occurred_flag;
    logic watchdog_expired_flag;
    logic powerdown_flag;
    logic por_phase;
    wdrc_pkg::wdrc_seq_e state;
    logic [31:0] hold_cnt;
    logic [31:0] fault_cnt;
    logic [31:0] bor_cnt;
    logic fault_key;
    logic fault_lvl;
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic xtal_last;
    logic [15:0] div_cnt;
    logic int_tick;
    logic xtal_tick;
    logic low_sync;
    logic [4:0] key_code;
    logic key_bad;
    logic [2:0] lvl_dec;
    logic lvl_bad;
    logic bor_evt;
    logic wdt_evt;
    logic wake_evt;
    logic fault_fire;
    logic flt_evt;
    logic full_evt;
    logic wr_en;
    logic setup;
    logic hit_wdt;
    logic hit_flags;
    logic hit_lvl;
    logic addr_ok;
    logic [7:0] rd_byte;

    // pins from other domains pass two flops before use
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            xtal_last <= 1'b0;
        end
        else
        begin
            pin_meta <= {low_supply_i, crystal_slow_oscillator_i};
            pin_sync <= pin_meta;
            xtal_last <= pin_sync[0];
        end
    end
    assign low_sync = pin_sync[1];
    assign xtal_tick = pin_sync[0] && !xtal_last;

    // internal slow oscillator stands in as a divider of the system clock
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            div_cnt <= 16'h0;
        else if (int_tick)
            div_cnt <= 16'h0;
        else
            div_cnt <= div_cnt + 16'h1;
    end
    assign int_tick = (div_cnt == 16'(SLOW_DIV - 1));

    assign cnt_if.tick = slow_source_crystal_i ? xtal_tick : int_tick; // see RQ1
    assign cnt_if.sel = watchdog_control[2:0];

    // event decode
    assign key_code = watchdog_control[7:3];
    assign key_bad = (key_code != `WDRC_KEY_ENABLE) && (key_code != `WDRC_KEY_DISABLE); // see RQ4
    assign cnt_if.run = (key_code == `WDRC_KEY_ENABLE) && (state != wdrc_pkg::seq_hold); // see RQ3
    assign lvl_dec = wdrc_pkg::wdrc_level_decode(brownout_level_select);
    assign lvl_bad = !lvl_dec[2]; // see RQ13
    assign brownout_threshold_o = lvl_dec[1:0]; // see RQ13
    assign bor_evt = low_sync && !power_down_i && (state != wdrc_pkg::seq_hold) &&
                     (bor_cnt == 32'(BOR_FILTER_CYC - 1)); // see RQ12
    assign wdt_evt = cnt_if.expire && !low_power_mode_i && !bor_evt; // see RQ6
    assign wake_evt = cnt_if.expire && low_power_mode_i && !bor_evt; // see RQ7
    assign fault_fire = (state == wdrc_pkg::seq_fault) &&
                        (fault_cnt == 32'(FAULT_DELAY_CYC - 1)); // see RQ20
    assign flt_evt = fault_fire && !bor_evt && !wdt_evt;
    assign full_evt = bor_evt || wdt_evt || flt_evt;

    // counter cleared by instruction, halt, fault reset, or any reset hold
    assign cnt_if.clear = clear_watchdog_instruction_i || halt_i || flt_evt ||
                          (state == wdrc_pkg::seq_hold); // see RQ8

    // brownout filter; power-down masks detection entirely
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            bor_cnt <= 32'h0;
        else if (!low_sync || power_down_i || bor_evt || state == wdrc_pkg::seq_hold)
            bor_cnt <= 32'h0; // see RQ17
        else
            bor_cnt <= bor_cnt + 32'h1; // see RQ12
    end

    // reset sequencer
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state <= wdrc_pkg::seq_hold;
            hold_cnt <= 32'h0;
            fault_cnt <= 32'h0;
            fault_key <= 1'b0;
            fault_lvl <= 1'b0;
        end
        else if (full_evt)
        begin
            state <= wdrc_pkg::seq_hold; // see RQ4
            hold_cnt <= 32'h0;
        end
        else
        begin
            case (state)
                wdrc_pkg::seq_run:
                begin
                    if (key_bad || lvl_bad)
                    begin
                        state <= wdrc_pkg::seq_fault; // see RQ14
                        fault_cnt <= 32'h0;
                        fault_key <= key_bad;
                        fault_lvl <= lvl_bad;
                    end
                end
                wdrc_pkg::seq_fault:
                    fault_cnt <= fault_cnt + 32'h1;
                wdrc_pkg::seq_hold:
                begin
                    if (hold_cnt == 32'(POR_DELAY_CYC - 1))
                        state <= wdrc_pkg::seq_run; // see RQ10
                    else
                        hold_cnt <= hold_cnt + 32'h1;
                end
                default:
                    state <= wdrc_pkg::seq_hold;
            endcase
        end
    end
    assign device_reset_o = (state == wdrc_pkg::seq_hold);
    assign cpu_run_o = (state != wdrc_pkg::seq_hold);

    // port preset lasts only through the very first hold after power-on
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            por_phase <= 1'b1;
        else if (state == wdrc_pkg::seq_hold && hold_cnt == 32'(POR_DELAY_CYC - 1))
            por_phase <= 1'b0; // see RQ11
    end
    assign port_preset_o = por_phase;

    // apb decode
    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pwrite_i && cpu_run_o;
    assign pready_o = 1'b1;
    always_comb
    begin
        hit_wdt = 1'b0;
        hit_flags = 1'b0;
        hit_lvl = 1'b0;
        addr_ok = 1'b1;
        rd_byte = 8'h00;
        if (paddr_i == `WDRC_OFS_WDT_CTRL)
        begin
            hit_wdt = 1'b1;
            rd_byte = watchdog_control;
        end
        else if (paddr_i == `WDRC_OFS_SYS_FLAGS)
        begin
            hit_flags = 1'b1;
            rd_byte[`WDRC_FLAG_KEEP_BIT] = idle_clock_keep; // see RQ18
            rd_byte[`WDRC_FLAG_BOR_BIT] = brownout_occurred_flag;
            rd_byte[`WDRC_FLAG_LVL_BIT] = level_select_fault_flag;
            rd_byte[`WDRC_FLAG_KEY_BIT] = watchdog_key_fault_flag;
        end
        else if (paddr_i == `WDRC_OFS_LVL_SEL)
        begin
            hit_lvl = 1'b1;
            rd_byte = brownout_level_select;
        end
        else if (paddr_i == `WDRC_OFS_STATUS)
        begin
            rd_byte[`WDRC_STAT_TO_BIT] = watchdog_expired_flag;
            rd_byte[`WDRC_STAT_PD_BIT] = powerdown_flag;
        end
        else
            addr_ok = 1'b0;
    end

    // read data captured in setup so it stands through the access phase
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            prdata_o <= 32'h0;
            pslverr_o <= 1'b0;
        end
        else if (setup)
        begin
            prdata_o <= {24'h0, rd_byte};
            pslverr_o <= !addr_ok;
        end
        else
            pslverr_o <= 1'b0;
    end

    // watchdog control
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            watchdog_control <= `WDRC_WDT_CTRL_RST; // see RQ9
        else if (full_evt)
            watchdog_control <= `WDRC_WDT_CTRL_RST;
        else if (wr_en && hit_wdt)
            watchdog_control <= pwdata_i[7:0];
    end

    // level select; a real brownout leaves it alone
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            brownout_level_select <= `WDRC_LVL_SEL_RST; // see RQ16
        else if (wdt_evt || flt_evt)
            brownout_level_select <= `WDRC_LVL_SEL_RST; // see RQ14
        else if (wr_en && hit_lvl && !bor_evt)
            brownout_level_select <= pwdata_i[7:0]; // see RQ15
    end

    // cause flags: hardware set beats a same-cycle software clear
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            idle_clock_keep <= 1'b0;
            watchdog_key_fault_flag <= 1'b0;
            level_select_fault_flag <= 1'b0;
            brownout_occurred_flag <= 1'b0;
        end
        else
        begin
            if (full_evt)
                idle_clock_keep <= 1'b0;
            else if (wr_en && hit_flags)
                idle_clock_keep <= pwdata_i[`WDRC_FLAG_KEEP_BIT];
            if (flt_evt && fault_key)
                watchdog_key_fault_flag <= 1'b1; // see RQ5
            else if (wr_en && hit_flags && !pwdata_i[`WDRC_FLAG_KEY_BIT])
                watchdog_key_fault_flag <= 1'b0; // see RQ5
            if (flt_evt && fault_lvl)
                level_select_fault_flag <= 1'b1; // see RQ14
            else if (wr_en && hit_flags && !pwdata_i[`WDRC_FLAG_LVL_BIT])
                level_select_fault_flag <= 1'b0;
            if (bor_evt)
                brownout_occurred_flag <= 1'b1; // see RQ12
            else if (wr_en && hit_flags && !pwdata_i[`WDRC_FLAG_BOR_BIT])
                brownout_occurred_flag <= 1'b0;
        end
    end
    assign idle_clock_keep_o = idle_clock_keep;

    // status flags and the sleep wake-up pulse
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            watchdog_expired_flag <= 1'b0;
            powerdown_flag <= 1'b0;
            pc_sp_clear_o <= 1'b0;
        end
        else
        begin
            if (wdt_evt || wake_evt)
                watchdog_expired_flag <= 1'b1; // see RQ6
            else if (clear_watchdog_instruction_i || halt_i)
                watchdog_expired_flag <= 1'b0;
            if (halt_i)
                powerdown_flag <= 1'b1; // see RQ19
            else if (clear_watchdog_instruction_i)
                powerdown_flag <= 1'b0; // see RQ19
            pc_sp_clear_o <= wake_evt; // see RQ7
        end
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);

    AST_FAULT_DELAY: assert property (flt_evt |-> $past(fault_cnt) == 32'(FAULT_DELAY_CYC - 2)) // see RQ20
        else $error("fault reset before its delay");
    AST_KEY_FAULT_RESET: assert property (flt_evt && fault_key |=> // see RQ4
        device_reset_o && watchdog_key_fault_flag && watchdog_control == `WDRC_WDT_CTRL_RST)
        else $error("key fault did not reset");
    AST_KEY_FLAG_STICKY: assert property (watchdog_key_fault_flag && // see RQ5
        !(wr_en && hit_flags && !pwdata_i[`WDRC_FLAG_KEY_BIT]) |=> watchdog_key_fault_flag)
        else $error("key fault flag lost");
    AST_WDT_RESET: assert property (wdt_evt |=> device_reset_o && watchdog_expired_flag) // see RQ6
        else $error("overflow without device reset");
    AST_WDT_WAKE: assert property (wake_evt |=> // see RQ7
        pc_sp_clear_o && watchdog_expired_flag && !device_reset_o ##1 !pc_sp_clear_o)
        else $error("sleep overflow handled wrongly");
    AST_POR_DELAY: assert property ($rose(cpu_run_o) |-> // see RQ10
        $past(hold_cnt) == 32'(POR_DELAY_CYC - 1))
        else $error("execution released early");
    AST_PORT_PRESET: assert property (port_preset_o |-> device_reset_o) // see RQ11
        else $error("port preset outside power-on hold");
    AST_BOR_SHORT: assert property (!low_sync |=> !bor_evt) // see RQ12
        else $error("short low supply caused reset");
    AST_LVL_FAULT: assert property (flt_evt && fault_lvl |=> // see RQ14
        level_select_fault_flag && brownout_level_select == `WDRC_LVL_SEL_RST)
        else $error("bad level code not restored");
    AST_BOR_KEEPS_LVL: assert property (bor_evt |=> $stable(brownout_level_select)) // see RQ15
        else $error("brownout changed level select");
    AST_PD_NO_BOR: assert property (power_down_i |-> !bor_evt) // see RQ17
        else $error("brownout in power-down");
    AST_RSVD_ZERO: assert property (setup && paddr_i == `WDRC_OFS_SYS_FLAGS |=> // see RQ18
        prdata_o[6:3] == 4'h0)
        else $error("reserved flag bits not zero");
    AST_PDF_SET: assert property (halt_i |=> powerdown_flag) // see RQ19
        else $error("halt did not set power-down flag");

    COV_WDT_RESET: cover property (wdt_evt);
    COV_KEY_FAULT: cover property (flt_evt && fault_key);
    COV_BROWNOUT: cover property (bor_evt);
    COV_WAKE: cover property (wake_evt);
endmodule
`default_nettype wire

/* File: common/wdrc_consts.svh */
// Notes on behaviour
// RQ1: watchdog counts slow sub-clock ticks, internal or crystal
// RQ2: select code gives period 2^8 to 2^18 ticks
// RQ3: key 10101 disables, 01010 enables the watchdog
// RQ4: any other key: delayed full reset, key flag
// RQ5: key fault flag set by hardware, cleared writing zero
// RQ6: overflow in normal run: device reset, expired flag
// RQ7: overflow in sleep/idle: expired flag, clear pc/sp only
// RQ8: counter cleared by key fault, clear, halt
// RQ9: control register powers up 0x53, watchdog running
// RQ10: hold execution for power-on delay, then start
// RQ11: power-on reset presets port registers to ones
// RQ12: brownout resets only after filter time elapses
// RQ13: four level codes accepted, each picks a threshold
// RQ14: bad level code: delayed reset, flag, restore register
// RQ15: brownout reset keeps level register unchanged
// RQ16: level register powers up 01010101
// RQ17: brownout detection off in power-down mode
// RQ18: flag register bits 6 to 3 read zero
// RQ19: halt sets power-down flag, clear instruction clears it
// RQ20: fault delay and brownout filter are cycle parameters
// RQ21: new period select applies from the next clear or overflow
`ifndef WDRC_CONSTS_SVH
`define WDRC_CONSTS_SVH
`define WDRC_OFS_WDT_CTRL 8'h00
`define WDRC_OFS_SYS_FLAGS 8'h04
`define WDRC_OFS_LVL_SEL 8'h08
`define WDRC_OFS_STATUS 8'h0c
`define WDRC_WDT_CTRL_RST 8'h53
`define WDRC_LVL_SEL_RST 8'h55
`define WDRC_KEY_ENABLE 5'h0a
`define WDRC_KEY_DISABLE 5'h15
`define WDRC_LVL_2V10 8'h55
`define WDRC_LVL_2V55 8'h33
`define WDRC_LVL_3V15 8'h99
`define WDRC_LVL_3V80 8'haa
`define WDRC_FLAG_KEEP_BIT 7
`define WDRC_FLAG_BOR_BIT 2
`define WDRC_FLAG_LVL_BIT 1
`define WDRC_FLAG_KEY_BIT 0
`define WDRC_STAT_TO_BIT 0
`define WDRC_STAT_PD_BIT 1
`define WDRC_TO_EXP0 8
`define WDRC_TO_EXP1 10
`define WDRC_TO_EXP2 12
`define WDRC_TO_EXP3 14
`define WDRC_TO_EXP4 15
`define WDRC_TO_EXP5 16
`define WDRC_TO_EXP6 17
`define WDRC_TO_EXP7 18
`define WDRC_CLK_HZ 25000000
`define WDRC_SLOW_HZ 32000
`define WDRC_SLOW_DIV (`WDRC_CLK_HZ / `WDRC_SLOW_HZ)
`define WDRC_POR_DELAY_MS 50
`define WDRC_POR_DELAY_CYC (`WDRC_CLK_HZ / 1000 * `WDRC_POR_DELAY_MS)
`define WDRC_FAULT_DELAY_CYC 64
`define WDRC_BOR_FILTER_CYC 32
`endif

/* File: common/wdrc_pkg.sv */
`include "wdrc_consts.svh"
`default_nettype none
package wdrc_pkg;
    typedef enum logic [2:0] {
        seq_run = 3'b001,
        seq_fault = 3'b010,
        seq_hold = 3'b100
    } wdrc_seq_e;
    typedef logic [17:0] wdrc_count_t;
    // last count value of a period of 2^n ticks
    function automatic wdrc_count_t wdrc_last(input logic [2:0] sel);
        int exp_n;
        case (sel)
            3'h0: exp_n = `WDRC_TO_EXP0;
            3'h1: exp_n = `WDRC_TO_EXP1;
            3'h2: exp_n = `WDRC_TO_EXP2;
            3'h3: exp_n = `WDRC_TO_EXP3;
            3'h4: exp_n = `WDRC_TO_EXP4;
            3'h5: exp_n = `WDRC_TO_EXP5;
            3'h6: exp_n = `WDRC_TO_EXP6;
            default: exp_n = `WDRC_TO_EXP7;
        endcase
        return wdrc_count_t'((64'h1 << exp_n) - 64'h1);
    endfunction
    // {valid, threshold index}
    function automatic logic [2:0] wdrc_level_decode(input logic [7:0] code);
        case (code)
            `WDRC_LVL_2V10: return 3'h4;
            `WDRC_LVL_2V55: return 3'h5;
            `WDRC_LVL_3V15: return 3'h6;
            `WDRC_LVL_3V80: return 3'h7;
            default: return 3'h0;
        endcase
    endfunction
endpackage
`default_nettype wire

/* File: common/wdrc_cnt_if.sv */
`default_nettype none
interface wdrc_cnt_if;
    logic tick;
    logic run;
    logic clear;
    logic [2:0] sel;
    logic expire;
    wdrc_pkg::wdrc_count_t count;
    modport ctl (output tick, run, clear, sel, input expire, count);
    modport cnt (input tick, run, clear, sel, output expire, count);
endinterface
`default_nettype wire

/* File: src/wdrc_counter.sv */
`include "wdrc_consts.svh"
`default_nettype none
module wdrc_counter (
    // clock and reset
    input wire logic clock_i,
    input wire logic arst_n_i,
    // control from the reset logic
    wdrc_cnt_if.cnt bus
);
    logic [2:0] sel_held;
    wdrc_pkg::wdrc_count_t last;
    logic wrap;

    assign last = wdrc_pkg::wdrc_last(sel_held); // see RQ2
    assign wrap = bus.run && bus.tick && !bus.clear && (bus.count == last);
    assign bus.expire = wrap;

    // period only swaps at a zero count, so a running count is never cut short
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            sel_held <= 3'(`WDRC_WDT_CTRL_RST);
        else if (bus.clear || wrap)
            sel_held <= bus.sel; // see RQ21
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            bus.count <= '0;
        else if (bus.clear || !bus.run || wrap)
            bus.count <= '0; // see RQ8
        else if (bus.tick)
            bus.count <= bus.count + 18'h1;
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);

    AST_CLEAR_ZERO: assert property (bus.clear |=> bus.count == '0) // see RQ8
        else $error("counter not zero after clear");
    AST_COUNT_BOUND: assert property (bus.count <= last) // see RQ2
        else $error("count passed the selected period");
    AST_SEL_HOLD: assert property (!bus.clear && !wrap |=> $stable(sel_held)) // see RQ21
        else $error("period changed outside a clear");
endmodule
`default_nettype wire

/* File: bench/wdrc_core_model.sv */
`default_nettype none
module wdrc_core_model (
    // clock
    input wire logic clock_i,
    // instructions and core modes
    output logic clear_o,
    output logic halt_o,
    output logic sleep_o,
    output logic pdown_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        clear_o = 1'b0;
        halt_o = 1'b0;
        sleep_o = 1'b0;
        pdown_o = 1'b0;
    end
    // one instruction a call, one cycle wide
    task automatic issue(input logic hlt);
        @(posedge clock_i);
        clear_o <= !hlt;
        halt_o <= hlt;
        @(posedge clock_i);
        clear_o <= 1'b0;
        halt_o <= 1'b0;
    endtask
    task automatic mode(input logic s, input logic p);
        @(posedge clock_i);
        sleep_o <= s;
        pdown_o <= p;
    endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int POR = 20;
    localparam int FLT = 8;
    localparam int BOR = 4;
    logic clock_i = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic xtal = 1'b0;
    logic low = 1'b0;
    logic xsel = 1'b0;
    logic keep;
    logic clr, hlt, slp, pdn, prdy, perr, rst, run, pre, pcsp, er;
    logic [31:0] prdata, rd;
    logic [1:0] thr;
    int err_total = 0;
    int num_checks = 0;
    int n;
    initial
    begin
        forever #20 clock_i = ~clock_i;
    end
    // crystal pin free-running; xsel makes it the tick source
    always @(posedge clock_i) xtal <= ~xtal;
    wdrc_top #(.POR_DELAY_CYC(POR), .FAULT_DELAY_CYC(FLT), .BOR_FILTER_CYC(BOR),
        .SLOW_DIV(4)) dut (
        .clock_i(clock_i), .arst_n_i(arst_n), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(prdy), .pslverr_o(perr), .clear_watchdog_instruction_i(clr),
        .halt_i(hlt), .low_power_mode_i(slp), .power_down_i(pdn),
        .slow_source_crystal_i(xsel), .crystal_slow_oscillator_i(xtal),
        .low_supply_i(low), .device_reset_o(rst), .cpu_run_o(run),
        .port_preset_o(pre), .pc_sp_clear_o(pcsp), .brownout_threshold_o(thr),
        .idle_clock_keep_o(keep));
    wdrc_core_model core (.clock_i(clock_i), .clear_o(clr), .halt_o(hlt),
        .sleep_o(slp), .pdown_o(pdn));
    task automatic tally_and_finish;
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clock_i);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        pen <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clock_i);
            k++;
        end
        while (prdy !== 1'b1 && k < 16);
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (prdy !== 1'b1)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    function automatic logic hit(input int w);
        return (w == 0) ? rst : ((w == 1) ? run : pcsp);
    endfunction
    // counts settled cycles until the watched output goes high
    task automatic wt(input int w, input int mx, input logic must);
        n = 0;
        while (hit(w) !== 1'b1 && n < mx)
        begin
            @(negedge clock_i);
            n++;
        end
        if (must && hit(w) !== 1'b1)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic sc_por;
        chk("preset", 32'h1, {31'h0, pre});
        wt(1, 100, 1'b1);
        // release lands just after edge zero, so one more settled cycle is counted
        chk("hold", 32'(POR + 1), 32'(n));
        chk("preset", 32'h0, {31'h0, pre});
        rdc(8'h00, 32'h53, "ctrl");
        rdc(8'h08, 32'h55, "level");
        apb(1'b1, 8'h04, 32'hff);
        rdc(8'h04, 32'h80, "flags");
        chk("keep", 32'h1, {31'h0, keep});
        rdc(8'h10, 32'h0, "unmapped");
        chk("slverr", 32'h1, {31'h0, er});
        apb(1'b1, 8'h04, 32'h0);
    endtask
    task automatic sc_expire;
        apb(1'b1, 8'h00, 32'h50);
        core.issue(1'b0);
        wt(0, 1200, 1'b1);
        chk("period", 32'h1, {31'h0, n > 976 && n < 1064});
        wt(1, 100, 1'b1);
        rdc(8'h0c, 32'h1, "status");
        // crystal edges come every second clock, so the period halves
        xsel <= 1'b1;
        apb(1'b1, 8'h00, 32'h50);
        core.issue(1'b0);
        wt(0, 700, 1'b1);
        chk("xtal period", 32'h1, {31'h0, n > 496 && n < 528});
        @(posedge clock_i);
        xsel <= 1'b0;
        wt(1, 100, 1'b1);
    endtask
    task automatic sc_sleep;
        apb(1'b1, 8'h00, 32'h50);
        core.mode(1'b1, 1'b0);
        core.issue(1'b1);
        rdc(8'h0c, 32'h2, "status");
        wt(2, 1200, 1'b1);
        chk("reset", 32'h0, {31'h0, rst});
        rdc(8'h0c, 32'h3, "status");
        core.mode(1'b0, 1'b0);
        core.issue(1'b0);
        rdc(8'h0c, 32'h0, "status");
    endtask
    task automatic sc_badkey;
        apb(1'b1, 8'h00, 32'ha8);
        wt(0, 1500, 1'b0);
        chk("disabled", 32'd1500, 32'(n));
        apb(1'b1, 8'h00, 32'h03);
        wt(0, 40, 1'b1);
        chk("fault delay", 32'h1, {31'h0, n >= FLT});
        wt(1, 100, 1'b1);
        rdc(8'h04, 32'h01, "flags");
        rdc(8'h00, 32'h53, "ctrl");
        apb(1'b1, 8'h04, 32'h0);
        rdc(8'h04, 32'h0, "flags");
    endtask
    task automatic sc_level;
        logic [7:0] c [4];
        c = '{8'h55, 8'h33, 8'h99, 8'haa};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, 8'h08, {24'h0, c[i]});
            @(negedge clock_i);
            chk("threshold", 32'(i), {30'h0, thr});
        end
        apb(1'b1, 8'h08, 32'h12);
        wt(0, 40, 1'b1);
        wt(1, 100, 1'b1);
        rdc(8'h04, 32'h02, "flags");
        rdc(8'h08, 32'h55, "level");
        apb(1'b1, 8'h04, 32'h0);
    endtask
    task automatic sc_brown;
        apb(1'b1, 8'h08, 32'h33);
        core.mode(1'b0, 1'b1);
        low <= 1'b1;
        wt(0, 20, 1'b0);
        chk("masked", 32'd20, 32'(n));
        @(posedge clock_i);
        low <= 1'b0;
        core.mode(1'b0, 1'b0);
        low <= 1'b1;
        repeat (2) @(posedge clock_i);
        low <= 1'b0;
        wt(0, 20, 1'b0);
        chk("glitch", 32'd20, 32'(n));
        @(posedge clock_i);
        low <= 1'b1;
        wt(0, 40, 1'b1);
        chk("filter", 32'h1, {31'h0, n >= BOR});
        @(posedge clock_i);
        low <= 1'b0;
        wt(1, 100, 1'b1);
        rdc(8'h04, 32'h04, "flags");
        rdc(8'h08, 32'h33, "level");
    endtask
    initial
    begin
        repeat (20) @(posedge clock_i);
        arst_n <= 1'b1;
        sc_por();
        sc_expire();
        sc_sleep();
        sc_badkey();
        sc_level();
        sc_brown();
        tally_and_finish();
    end
endmodule
`default_nettype wire
